// >>> common/audio_ctrl_defs.svh
// Register offsets, field positions, reset values and mode patterns of the audio control block.
// Assumes inclusion by bare name from files under core/.
`ifndef AUDIO_CTRL_DEFS_SVH
`define AUDIO_CTRL_DEFS_SVH

// Register indices; the AXI byte address is four times the index.
`define IDX_DAC_LIM_LO 8'h2D
`define IDX_DAC_LIM_HI 8'h2E
`define IDX_DAC_WRITE 8'h2F
`define IDX_GAIN_CTRL 8'h30
`define IDX_WDOG_SEL 8'h40
`define IDX_DIV_CTRL 8'h41
`define IDX_DIV_COUNT 8'h42
`define IDX_REC_IN_LO 8'h43
`define IDX_REC_IN_HI 8'h44
`define IDX_DAC_STATUS 8'h45

// Field positions.
`define POS_REC_SRC 0
`define POS_LOAD_STROBE 3
`define POS_ADC_RESET 6
`define POS_MIC_SILENCE_N 7
`define POS_AMP_SRC 0
`define POS_PIN_SEL 1
`define POS_DIV_EN 4
`define POS_PRESC_LO 5

// Reset values.
`define RST_GAIN_CTRL 8'h00
`define RST_WDOG_SEL 8'h00
`define RST_DAC_LIM 8'h00

// Upper nibble of the watchdog select register that selects direct DAC writes.
`define DIRECT_PATTERN 4'h5
// Gain code at which the gain saturates.
`define GAIN_MAX_CODE 6'h27
`define GAIN_FRAC_BITS 12

`endif

// >>> common/audio_ctrl_pkg.sv
// Types shared by the audio control block.
// Assumes no other package.
package audio_ctrl_pkg;
  typedef logic [15:0] sample_t;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;
endpackage

// >>> common/divider_if.sv
// Connection between the register file and the frequency divider core.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface divider_if;
  logic enable;
  logic [1:0] presc_sel;
  logic [7:0] count;
  logic div_out;
  modport ctrl (output enable, output presc_sel, output count, input div_out);
  modport core (input enable, input presc_sel, input count, output div_out);
endinterface

// >>> core/freq_divider.sv
// Prescaler and reloading 8-bit counter that produce a square wave.
// Assumes the divider source clock is the system clock.
`timescale 1ns/100ps
`include "audio_ctrl_defs.svh"
module freq_divider (
  input wire logic clk,
  input wire logic rst,
  divider_if.core dif
);
  logic [2:0] presc_ff, nxt_presc;
  logic [7:0] cnt_ff, nxt_cnt;
  logic out_ff, nxt_out;
  logic [2:0] presc_top;
  logic tick;

  always_comb begin
    presc_top = 3'((4'h1 << dif.presc_sel) - 4'h1);
    tick = (presc_ff == presc_top);
    nxt_presc = presc_ff;
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    if (!dif.enable) begin
      nxt_presc = 3'h0;
      nxt_cnt = 8'h00;
      nxt_out = 1'b0;
    end else begin
      nxt_presc = tick ? 3'h0 : presc_ff + 3'h1;
      if (tick) begin
        if (cnt_ff == 8'h00) begin
          nxt_cnt = dif.count;
          nxt_out = ~out_ff;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      presc_ff <= 3'h0;
      cnt_ff <= 8'h00;
      out_ff <= 1'b0;
    end else begin
      presc_ff <= nxt_presc;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign dif.div_out = out_ff;

  a_div_idle_low: assert property (@(posedge clk) disable iff (rst) !dif.enable |=> !dif.div_out)
    else $error("divider output not low while disabled");
  a_presc_wrap: assert property (@(posedge clk) disable iff (rst)
    dif.enable && $past(dif.enable) && tick |=> presc_ff == 3'h0)
    else $error("prescaler did not wrap at its top");
  c_div_toggle: cover property (@(posedge clk) disable iff (rst) dif.enable && $rose(out_ff));
endmodule

// >>> core/audio_ctrl.sv
// Audio path control: direct DAC writes and DAC limit, record gain stage, ADC reset,
// amplifier source select and frequency divider with its pin mux, behind an AXI4-Lite slave.
// Assumes samples on ADC_*, HOST_* and GPIO_* come from logic on CLK; USB_BUS_RESET is a pin.
`timescale 1ns/100ps
`include "audio_ctrl_defs.svh"
module audio_ctrl (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic USB_BUS_RESET,
  input wire logic [15:0] ADC_SAMPLE,
  input wire logic ADC_VALID,
  input wire logic [15:0] HOST_SAMPLE,
  input wire logic HOST_VALID,
  output logic [15:0] DAC_CODE,
  output logic DAC_LOAD,
  output logic [15:0] REC_SAMPLE,
  output logic REC_VALID,
  output logic ADC_RESET,
  output logic AMP_SOURCE_MUSIC,
  input wire logic GPIO_PC0_O,
  input wire logic GPIO_PC0_OE,
  output logic PORT_C_PIN0_O,
  output logic PORT_C_PIN0_OE
);
  ////////////////////////////////////////////////////////////////////////////////
  // Gain lookup: 12 half-dB steps per octave, then a shift by whole octaves.
  function automatic audio_ctrl_pkg::sample_t apply_gain(input audio_ctrl_pkg::sample_t s, input logic [5:0] g);
    logic [5:0] gc;
    logic [13:0] base;
    logic signed [35:0] p;
    gc = (g > `GAIN_MAX_CODE) ? `GAIN_MAX_CODE : g;
    unique case (gc % 6'd12)
      6'd0: base = 14'h1000;
      6'd1: base = 14'h10F4;
      6'd2: base = 14'h11F6;
      6'd3: base = 14'h1307;
      6'd4: base = 14'h1429;
      6'd5: base = 14'h155C;
      6'd6: base = 14'h16A1;
      6'd7: base = 14'h17F9;
      6'd8: base = 14'h1966;
      6'd9: base = 14'h1AE9;
      6'd10: base = 14'h1C82;
      default: base = 14'h1E34;
    endcase
    p = 36'($signed(s) * $signed({1'b0, base})) >>> `GAIN_FRAC_BITS;
    p = p <<< (gc / 6'd12);
    if (p > 36'sh00000_7FFF) begin
      return 16'h7FFF;
    end else if (p < -36'sh00000_8000) begin
      return 16'h8000;
    end
    return p[15:0];
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[1:0] == 2'b00) && (a[11:10] == 2'b00) &&
      ((i >= `IDX_DAC_LIM_LO && i <= `IDX_GAIN_CTRL) || (i >= `IDX_WDOG_SEL && i <= `IDX_DAC_STATUS));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // USB reset pin: three stages, a change is accepted once stages two and three agree.
  logic usb_s1_ff, usb_s2_ff, usb_s3_ff, usb_rst_ff, nxt_usb_rst;
  always_comb begin
    nxt_usb_rst = (usb_s2_ff == usb_s3_ff) ? usb_s3_ff : usb_rst_ff;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      usb_s1_ff <= 1'b0;
      usb_s2_ff <= 1'b0;
      usb_s3_ff <= 1'b0;
      usb_rst_ff <= 1'b0;
    end else begin
      usb_s1_ff <= USB_BUS_RESET;
      usb_s2_ff <= usb_s1_ff;
      usb_s3_ff <= usb_s2_ff;
      usb_rst_ff <= nxt_usb_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: one write and one read at a time.
  logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got, bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [11:0] awaddr_ff, nxt_awaddr;
  logic [7:0] wbyte_ff, nxt_wbyte;
  logic wlane_ff, nxt_wlane;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata, rmux;
  logic wen;
  logic [7:0] widx;

  assign S_AXI_AWREADY = !aw_got_ff && !bvalid_ff;
  assign S_AXI_WREADY = !w_got_ff && !bvalid_ff;
  assign S_AXI_ARREADY = !rvalid_ff;
  assign wen = aw_got_ff && w_got_ff;
  assign widx = awaddr_ff[9:2];

  // Register state.
  logic [7:0] wdog_ff, nxt_wdog, lim_lo_ff, nxt_lim_lo, lim_hi_ff, nxt_lim_hi, gain_ff, nxt_gain;
  logic [7:0] cnt_val_ff, nxt_cnt_val, rec_lo_ff, nxt_rec_lo, rec_hi_ff, nxt_rec_hi;
  logic rec_src_ff, nxt_rec_src, strobe_ff, nxt_strobe, div_en_ff, nxt_div_en;
  logic pin_sel_ff, nxt_pin_sel, amp_sel_ff, nxt_amp_sel;
  logic [1:0] presc_ff, nxt_presc;
  logic rec_hi_wr;
  logic [7:0] div_ctrl_rd;

  assign div_ctrl_rd = {1'b0, presc_ff, div_en_ff, 2'b00, pin_sel_ff, amp_sel_ff};

  always_comb begin
    unique case (S_AXI_ARADDR[9:2])
      `IDX_DAC_LIM_LO: rmux = {24'h000000, lim_lo_ff};
      `IDX_DAC_LIM_HI: rmux = {24'h000000, lim_hi_ff};
      `IDX_DAC_WRITE: rmux = {28'h0000000, strobe_ff, 2'b00, rec_src_ff};
      `IDX_GAIN_CTRL: rmux = {24'h000000, gain_ff};
      `IDX_WDOG_SEL: rmux = {24'h000000, wdog_ff};
      `IDX_DIV_CTRL: rmux = {24'h000000, div_ctrl_rd};
      `IDX_DIV_COUNT: rmux = {24'h000000, cnt_val_ff};
      `IDX_REC_IN_LO: rmux = {24'h000000, rec_lo_ff};
      `IDX_REC_IN_HI: rmux = {24'h000000, rec_hi_ff};
      `IDX_DAC_STATUS: rmux = {16'h0000, DAC_CODE};
      default: rmux = 32'h00000000;
    endcase
  end

  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wbyte = wbyte_ff;
    nxt_wlane = wlane_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      nxt_w_got = 1'b1;
      nxt_wbyte = S_AXI_WDATA[7:0];
      nxt_wlane = S_AXI_WSTRB[0];
    end
    if (wen) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = is_mapped(awaddr_ff) ? audio_ctrl_pkg::RESP_OKAY : audio_ctrl_pkg::RESP_SLVERR;
    end else if (bvalid_ff && S_AXI_BREADY) begin
      nxt_bvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rmux;
      nxt_rresp = is_mapped(S_AXI_ARADDR) ? audio_ctrl_pkg::RESP_OKAY : audio_ctrl_pkg::RESP_SLVERR;
    end else if (rvalid_ff && S_AXI_RREADY) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wbyte_ff <= 8'h00;
      wlane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'b00;
    end else begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wbyte_ff <= nxt_wbyte;
      wlane_ff <= nxt_wlane;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RDATA = rdata_ff;
  assign S_AXI_RRESP = rresp_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes. Only byte lane 0 carries data; a write without it changes nothing.
  always_comb begin
    nxt_wdog = wdog_ff;
    nxt_lim_lo = lim_lo_ff;
    nxt_lim_hi = lim_hi_ff;
    nxt_gain = gain_ff;
    nxt_rec_src = rec_src_ff;
    nxt_strobe = strobe_ff;
    nxt_div_en = div_en_ff;
    nxt_presc = presc_ff;
    nxt_pin_sel = pin_sel_ff;
    nxt_amp_sel = amp_sel_ff;
    nxt_cnt_val = cnt_val_ff;
    nxt_rec_lo = rec_lo_ff;
    nxt_rec_hi = rec_hi_ff;
    rec_hi_wr = 1'b0;
    if (wen && wlane_ff) begin
      unique case (widx)
        `IDX_WDOG_SEL: nxt_wdog = wbyte_ff;
        `IDX_DAC_LIM_LO: nxt_lim_lo = wbyte_ff;
        `IDX_DAC_LIM_HI: nxt_lim_hi = wbyte_ff;
        `IDX_GAIN_CTRL: nxt_gain = wbyte_ff;
        `IDX_DAC_WRITE: begin
          nxt_rec_src = wbyte_ff[`POS_REC_SRC];
          nxt_strobe = wbyte_ff[`POS_LOAD_STROBE];
        end
        `IDX_DIV_CTRL: begin
          nxt_div_en = wbyte_ff[`POS_DIV_EN];
          nxt_presc = wbyte_ff[`POS_PRESC_LO +: 2];
          nxt_pin_sel = wbyte_ff[`POS_PIN_SEL];
          nxt_amp_sel = wbyte_ff[`POS_AMP_SRC];
        end
        `IDX_DIV_COUNT: nxt_cnt_val = div_en_ff ? wbyte_ff : cnt_val_ff;
        `IDX_REC_IN_LO: nxt_rec_lo = wbyte_ff;
        `IDX_REC_IN_HI: begin
          nxt_rec_hi = wbyte_ff;
          rec_hi_wr = 1'b1;
        end
        default: nxt_wdog = wdog_ff;
      endcase
    end
    if (!nxt_div_en) begin
      nxt_cnt_val = 8'h00;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wdog_ff <= `RST_WDOG_SEL;
      lim_lo_ff <= `RST_DAC_LIM;
      lim_hi_ff <= `RST_DAC_LIM;
      gain_ff <= `RST_GAIN_CTRL;
      rec_src_ff <= 1'b0;
      strobe_ff <= 1'b0;
      div_en_ff <= 1'b0;
      presc_ff <= 2'b00;
      pin_sel_ff <= 1'b0;
      amp_sel_ff <= 1'b0;
      cnt_val_ff <= 8'h00;
      rec_lo_ff <= 8'h00;
      rec_hi_ff <= 8'h00;
    end else begin
      wdog_ff <= nxt_wdog;
      lim_lo_ff <= nxt_lim_lo;
      lim_hi_ff <= nxt_lim_hi;
      gain_ff <= nxt_gain;
      rec_src_ff <= nxt_rec_src;
      strobe_ff <= nxt_strobe;
      div_en_ff <= nxt_div_en;
      presc_ff <= nxt_presc;
      pin_sel_ff <= nxt_pin_sel;
      amp_sel_ff <= nxt_amp_sel;
      cnt_val_ff <= nxt_cnt_val;
      rec_lo_ff <= nxt_rec_lo;
      rec_hi_ff <= nxt_rec_hi;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Audio datapath. While the direct pattern is selected every host sample is dropped,
  // and the converter is loaded only on a fall of the load strobe.
  logic direct_mode, strobe_fall;
  audio_ctrl_pkg::sample_t limit_word, src_sample, dac_ff, nxt_dac, rec_ff, nxt_rec;
  logic dac_load_ff, nxt_dac_load, rec_valid_ff, nxt_rec_valid, adc_rst_ff, nxt_adc_rst, src_valid;

  assign direct_mode = (wdog_ff[7:4] == `DIRECT_PATTERN);
  assign strobe_fall = strobe_ff && !nxt_strobe;
  assign limit_word = {lim_hi_ff, lim_lo_ff};

  always_comb begin
    nxt_dac = dac_ff;
    nxt_dac_load = 1'b0;
    if (direct_mode && strobe_fall) begin
      nxt_dac = limit_word;
      nxt_dac_load = 1'b1;
    end else if (!direct_mode && HOST_VALID) begin
      nxt_dac = (HOST_SAMPLE > limit_word) ? limit_word : HOST_SAMPLE;
      nxt_dac_load = 1'b1;
    end
    src_sample = rec_src_ff ? {wbyte_ff, rec_lo_ff} : ADC_SAMPLE;
    src_valid = rec_src_ff ? rec_hi_wr : (ADC_VALID && !adc_rst_ff);
    nxt_rec = rec_ff;
    nxt_rec_valid = src_valid;
    if (src_valid) begin
      nxt_rec = gain_ff[`POS_MIC_SILENCE_N] ? apply_gain(src_sample, gain_ff[5:0]) : 16'h0000;
    end
    nxt_adc_rst = gain_ff[`POS_ADC_RESET] || usb_rst_ff;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      dac_ff <= 16'h0000;
      dac_load_ff <= 1'b0;
      rec_ff <= 16'h0000;
      rec_valid_ff <= 1'b0;
      adc_rst_ff <= 1'b1;
    end else begin
      dac_ff <= nxt_dac;
      dac_load_ff <= nxt_dac_load;
      rec_ff <= nxt_rec;
      rec_valid_ff <= nxt_rec_valid;
      adc_rst_ff <= nxt_adc_rst;
    end
  end

  assign DAC_CODE = dac_ff;
  assign DAC_LOAD = dac_load_ff;
  assign REC_SAMPLE = rec_ff;
  assign REC_VALID = rec_valid_ff;
  assign ADC_RESET = adc_rst_ff;
  assign AMP_SOURCE_MUSIC = amp_sel_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Frequency divider and pin C0.
  divider_if div_bus ();
  assign div_bus.enable = div_en_ff;
  assign div_bus.presc_sel = presc_ff;
  assign div_bus.count = cnt_val_ff;

  freq_divider u_divider (
    .clk(CLK),
    .rst(RST),
    .dif(div_bus.core)
  );

  assign PORT_C_PIN0_O = pin_sel_ff ? div_bus.div_out : GPIO_PC0_O;
  assign PORT_C_PIN0_OE = pin_sel_ff ? 1'b1 : GPIO_PC0_OE;

  ////////////////////////////////////////////////////////////////////////////////
  a_direct_load: assert property (@(posedge CLK) disable iff (RST)
    $fell(strobe_ff) && $past(direct_mode) |-> DAC_LOAD && DAC_CODE == $past(limit_word))
    else $error("direct DAC write not loaded on strobe fall");
  a_limit_clamp: assert property (@(posedge CLK) disable iff (RST)
    DAC_LOAD && !$past(direct_mode) |-> DAC_CODE <= $past(limit_word) && $past(HOST_VALID))
    else $error("DAC code above limit");
  a_gain_sat: assert property (@(posedge CLK) disable iff (RST)
    src_valid && gain_ff[7] && gain_ff[5:0] >= `GAIN_MAX_CODE
    |=> REC_VALID && REC_SAMPLE == apply_gain($past(src_sample), `GAIN_MAX_CODE))
    else $error("gain not saturated");
  a_mute_zero: assert property (@(posedge CLK) disable iff (RST)
    src_valid && !gain_ff[7] |=> REC_VALID && REC_SAMPLE == 16'h0000)
    else $error("muted sample not zero");
  a_adc_soft_rst: assert property (@(posedge CLK) disable iff (RST)
    gain_ff[6] |=> ADC_RESET)
    else $error("ADC reset bit not applied");
  a_adc_usb_rst: assert property (@(posedge CLK) disable iff (RST)
    usb_s3_ff && usb_s2_ff |=> ##1 ADC_RESET)
    else $error("USB reset did not reset ADC");
  a_count_clear: assert property (@(posedge CLK) disable iff (RST)
    !div_en_ff |-> cnt_val_ff == 8'h00)
    else $error("count register not cleared while disabled");
  a_pin_route: assert property (@(posedge CLK) disable iff (RST)
    pin_sel_ff |-> PORT_C_PIN0_OE && PORT_C_PIN0_O == div_bus.div_out)
    else $error("pin C0 not driven by divider");
  a_write_resp: assert property (@(posedge CLK) disable iff (RST)
    wen |=> S_AXI_BVALID)
    else $error("write response missing");
  c_direct_write: cover property (@(posedge CLK) disable iff (RST) $fell(strobe_ff) && direct_mode);
  c_host_clamp: cover property (@(posedge CLK) disable iff (RST) HOST_VALID && HOST_SAMPLE > limit_word);
  c_reg_record: cover property (@(posedge CLK) disable iff (RST) rec_hi_wr && rec_src_ff);
endmodule

// >>> testbench/audio_ctrl_tb.sv
// Self-checking bench for the audio control block: register bus, DAC paths, record path and divider.
// Assumes the design header is on the include path and the design files are compiled first.
`timescale 1ns/100ps
`include "audio_ctrl_defs.svh"
module audio_ctrl_tb;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [11:0] S_AXI_AWADDR = 12'h000, S_AXI_ARADDR = 12'h000;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic USB_BUS_RESET = 1'b0, ADC_VALID = 1'b0, HOST_VALID = 1'b0, GPIO_PC0_O = 1'b0, GPIO_PC0_OE = 1'b0;
  logic [15:0] ADC_SAMPLE = 16'h0, HOST_SAMPLE = 16'h0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, DAC_LOAD, REC_VALID;
  logic ADC_RESET, AMP_SOURCE_MUSIC, PORT_C_PIN0_O, PORT_C_PIN0_OE;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic [15:0] DAC_CODE, REC_SAMPLE;
  logic [33:0] rq[$];
  logic [15:0] dq[$];
  logic [15:0] eq[$];
  logic [1:0] bq[$];
  logic [33:0] e;
  logic [31:0] seed = 32'h21;
  int n_errors = 0;
  int checked = 0;

  audio_ctrl i_audio_ctrl (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .USB_BUS_RESET(USB_BUS_RESET), .ADC_SAMPLE(ADC_SAMPLE), .ADC_VALID(ADC_VALID), .HOST_SAMPLE(HOST_SAMPLE),
    .HOST_VALID(HOST_VALID), .DAC_CODE(DAC_CODE), .DAC_LOAD(DAC_LOAD), .REC_SAMPLE(REC_SAMPLE),
    .REC_VALID(REC_VALID), .ADC_RESET(ADC_RESET), .AMP_SOURCE_MUSIC(AMP_SOURCE_MUSIC),
    .GPIO_PC0_O(GPIO_PC0_O), .GPIO_PC0_OE(GPIO_PC0_OE), .PORT_C_PIN0_O(PORT_C_PIN0_O),
    .PORT_C_PIN0_OE(PORT_C_PIN0_OE));

  always #5 CLK = ~CLK;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Handshake flags are sampled on the falling edge, where nothing is moving, and acted on at the next rise.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic aw, w, b;
    b = 1'b0;
    bq.push_back((idx inside {[`IDX_DAC_LIM_LO:`IDX_GAIN_CTRL], [`IDX_WDOG_SEL:`IDX_DAC_STATUS]}) ? 2'b00 : 2'b10);
    S_AXI_AWADDR <= {2'b00, idx, 2'b00};
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!b) begin
      @(negedge CLK);
      aw = S_AXI_AWVALID && S_AXI_AWREADY;
      w = S_AXI_WVALID && S_AXI_WREADY;
      b = S_AXI_BVALID === 1'b1;
      @(posedge CLK);
      if (aw) S_AXI_AWVALID <= 1'b0;
      if (w) S_AXI_WVALID <= 1'b0;
    end
    S_AXI_BREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] resp);
    logic ar, r;
    r = 1'b0;
    rq.push_back({resp, d});
    S_AXI_ARADDR <= {2'b00, idx, 2'b00};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    while (!r) begin
      @(negedge CLK);
      ar = S_AXI_ARVALID && S_AXI_ARREADY;
      r = S_AXI_RVALID === 1'b1;
      @(posedge CLK);
      if (ar) S_AXI_ARVALID <= 1'b0;
    end
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK);
  endtask

  // Called at a falling edge; counts cycles until the pin next toggles.
  task automatic meas(output int n);
    logic v;
    v = PORT_C_PIN0_O;
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (PORT_C_PIN0_O === v && n < 300);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge CLK) begin
    if (!RST) begin
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        e = bq.size() ? {32'h0, bq.pop_front()} : 'x;
        check("bresp", {32'h0, S_AXI_BRESP}, e);
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        e = rq.size() ? rq.pop_front() : 'x;
        check("read", {S_AXI_RRESP, S_AXI_RDATA}, e);
      end
      if (DAC_LOAD === 1'b1) begin
        e = dq.size() ? {18'h0, dq.pop_front()} : 'x;
        check("dac_code", {18'h0, DAC_CODE}, e);
      end
      if (REC_VALID === 1'b1) begin
        e = eq.size() ? {18'h0, eq.pop_front()} : 'x;
        check("rec_sample", {18'h0, REC_SAMPLE}, e);
      end
    end
  end

  initial begin
    #500000;
    n_errors++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] lim, s;
    logic [7:0] n;
    int t;
    logic [15:0] gt[6][3];
    gt = '{'{16'h80, 16'h04D2, 16'h04D2}, '{16'h8C, 16'h0100, 16'h0200}, '{16'h98, 16'hFF00, 16'hFC00},
           '{16'hA7, 16'h0D80, 16'h7FFF}, '{16'hBF, 16'hF280, 16'h8000}, '{16'h3F, 16'h1234, 16'h0000}};
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    GPIO_PC0_O <= 1'(rnd());
    GPIO_PC0_OE <= 1'b0;
    @(posedge CLK);
    rd(`IDX_GAIN_CTRL, 32'h0, 2'b00);
    rd(`IDX_WDOG_SEL, 32'h0, 2'b00);
    rd(`IDX_DIV_CTRL, 32'h0, 2'b00);
    rd(8'h50, 32'h0, 2'b10);
    wr(8'h50, 8'hFF);
    S_AXI_WSTRB <= 4'hE;
    wr(`IDX_WDOG_SEL, 8'hFF);
    S_AXI_WSTRB <= 4'hF;
    rd(`IDX_WDOG_SEL, 32'h0, 2'b00);
    wr(`IDX_DIV_CTRL, 8'hFF);
    rd(`IDX_DIV_CTRL, 32'h73, 2'b00);
    check("amp_src", AMP_SOURCE_MUSIC, 34'h1);
    check("pin_oe", PORT_C_PIN0_OE, 34'h1);
    wr(`IDX_DIV_CTRL, 8'h00);
    check("pin_o", {PORT_C_PIN0_OE, PORT_C_PIN0_O}, {GPIO_PC0_OE, GPIO_PC0_O});
    check("amp_src", AMP_SOURCE_MUSIC, 34'h0);
    wr(`IDX_DIV_COUNT, 8'h55);
    rd(`IDX_DIV_COUNT, 32'h0, 2'b00);
    for (int p = 0; p < 4; p++) begin
      n = 8'(rnd()) & 8'h07;
      wr(`IDX_DIV_CTRL, 8'h12 | (p << 5));
      wr(`IDX_DIV_COUNT, n);
      rd(`IDX_DIV_COUNT, {24'h0, n}, 2'b00);
      @(negedge CLK);
      meas(t);
      meas(t);
      check("div_period", t, (n + 1) << p);
      @(posedge CLK);
    end
    wr(`IDX_DIV_CTRL, 8'h00);
    rd(`IDX_DIV_COUNT, 32'h0, 2'b00);
    wr(`IDX_WDOG_SEL, 8'h5A);
    wr(`IDX_DAC_LIM_LO, 8'h00);
    wr(`IDX_DAC_LIM_HI, 8'h80);
    wr(`IDX_DAC_WRITE, 8'h08);
    dq.push_back(16'h8000);
    wr(`IDX_DAC_WRITE, 8'h00);
    rd(`IDX_DAC_STATUS, 32'h8000, 2'b00);
    // Outside the direct pattern a strobe fall must not load; the monitor flags any stray load.
    wr(`IDX_WDOG_SEL, 8'h6A);
    wr(`IDX_DAC_WRITE, 8'h08);
    wr(`IDX_DAC_WRITE, 8'h00);
    repeat (6) begin
      lim = 16'(rnd());
      s = 16'(rnd());
      wr(`IDX_DAC_LIM_LO, lim[7:0]);
      wr(`IDX_DAC_LIM_HI, lim[15:8]);
      dq.push_back(s > lim ? lim : s);
      HOST_SAMPLE <= s;
      HOST_VALID <= 1'b1;
      @(posedge CLK);
      HOST_VALID <= 1'b0;
      @(posedge CLK);
    end
    wr(`IDX_DAC_WRITE, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(`IDX_GAIN_CTRL, gt[i][0][7:0]);
      wr(`IDX_REC_IN_LO, gt[i][1][7:0]);
      eq.push_back(gt[i][2]);
      wr(`IDX_REC_IN_HI, gt[i][1][15:8]);
    end
    wr(`IDX_DAC_WRITE, 8'h00);
    wr(`IDX_GAIN_CTRL, 8'h80);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) eq.push_back(16'h0321);
      ADC_SAMPLE <= 16'h0321;
      ADC_VALID <= 1'b1;
      @(posedge CLK);
      ADC_VALID <= 1'b0;
      @(negedge CLK);
      check("adc_reset", ADC_RESET, i);
      @(posedge CLK);
      wr(`IDX_GAIN_CTRL, i ? 8'h80 : 8'hC0);
    end
    USB_BUS_RESET <= 1'b1;
    repeat (8) @(posedge CLK);
    check("adc_reset", ADC_RESET, 34'h1);
    USB_BUS_RESET <= 1'b0;
    repeat (8) @(posedge CLK);
    check("adc_reset", ADC_RESET, 34'h0);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    check("adc_reset", ADC_RESET, 34'h1);
    @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rd(`IDX_GAIN_CTRL, 32'h0, 2'b00);
    repeat (4) @(posedge CLK);
    check("pending", dq.size() + eq.size() + rq.size() + bq.size(), 34'h0);
    end_sim();
  end
endmodule
